// ### hdl/ptmr_cfg.svh
/*
 Constants of the 10-bit periodic timer: register offsets, field
 positions, field codes and reset values.
 Assumes inclusion from the timer package and core only.
*/
`ifndef PTMR_CFG_SVH
`define PTMR_CFG_SVH

`define PTMR_OFS_CTL0    8'h00
`define PTMR_OFS_CTL1    8'h04
`define PTMR_OFS_CNTL    8'h08
`define PTMR_OFS_CNTH    8'h0C
`define PTMR_OFS_CMPAL   8'h10
`define PTMR_OFS_CMPAH   8'h14
`define PTMR_OFS_PERL    8'h18
`define PTMR_OFS_PERH    8'h1C

`define PTMR_RST_CTL0    8'h00
`define PTMR_RST_CTL1    8'h00
`define PTMR_RST_CMP     10'h000
`define PTMR_CTL0_MASK   8'hF8

`define PTMR_PAUSE_BIT   7
`define PTMR_CKS_HI      6
`define PTMR_CKS_LO      4
`define PTMR_ON_BIT      3
`define PTMR_MODE_HI     7
`define PTMR_MODE_LO     6
`define PTMR_IO_HI       5
`define PTMR_IO_LO       4
`define PTMR_OC_BIT      3
`define PTMR_POL_BIT     2
`define PTMR_CAPS_BIT    1
`define PTMR_CCLR_BIT    0

`define PTMR_MODE_CMP    2'h0
`define PTMR_MODE_CAP    2'h1
`define PTMR_MODE_PWM    2'h2
`define PTMR_MODE_TMR    2'h3

`define PTMR_IO_00       2'h0
`define PTMR_IO_01       2'h1
`define PTMR_IO_10       2'h2
`define PTMR_IO_11       2'h3

`define PTMR_CK_SYS4     3'h0
`define PTMR_CK_SYS      3'h1
`define PTMR_CK_H16      3'h2
`define PTMR_CK_H64      3'h3
`define PTMR_CK_SUB0     3'h4
`define PTMR_CK_SUB1     3'h5
`define PTMR_CK_XRISE    3'h6
`define PTMR_CK_XFALL    3'h7

`define PTMR_DIV4_LAST   2'h3
`define PTMR_H16_MASK    6'h0F
`define PTMR_H64_LAST    6'h3F
`define PTMR_FULL_PERIOD 11'h400

`endif

// ### hdl/ptmr_pkg.sv
/*
 Types of the 10-bit periodic timer: the APB request carrier and the
 packed state record of the core.
 Assumes ptmr_cfg.svh on the include path.
*/
package ptmr_pkg;
  `include "ptmr_cfg.svh"

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ptmr_apb_req_t;

  typedef struct packed {
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [9:0]  cmp_a;
    logic [9:0]  period;
    logic [9:0]  cnt;
    logic [1:0]  div4;
    logic [5:0]  hdiv;
    logic [2:0]  xsync;
    logic [2:0]  csync;
    logic        out_lvl;
    logic        pin;
    logic        flag_a;
    logic        flag_p;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ptmr_state_t;
endpackage

// ### hdl/ptmr_core.sv
/*
 10-bit periodic timer with comparators A and P, an APB register slave,
 compare output, capture, PWM, single pulse and timer modes.
 Assumes hs_tick and sub_tick are one-cycle enables made on clk_sys;
 the two pins arrive asynchronously and are synchronised here.
*/
// Overview of operation
// RL1: Ten-bit up-counter on selected clock source
// RL2: Pause bit freezes count, clearing resumes
// RL3: Three-bit field selects the counting clock
// RL4: On rising clears count, falling holds it
// RL5: On rising restores output initial level
// RL6: Software cannot write the counter directly
// RL7: Two-bit field selects operating mode
// RL8: Software turns module off before mode change
// RL9: Comparator A match drives pin per field
// RL10: Match equal to initial level shows nothing
// RL11: PWM field forces levels or enables outputs
// RL12: Software changes pin field only when off
// RL13: Capture field picks trigger edge or disables
// RL14: Capture source is capture pin or clock pin
// RL15: Output-control bit sets initial/active level
// RL16: Polarity bit inverts the output pin
// RL17: Clear-select picks comparator A or P clear
// RL18: Clear-select ignored in PWM, pulse, capture
// RL19: Comparator P compares all ten counter bits
// RL20: Automatic clears raise the interrupt request
// RL21: Count read as low byte and high bits
// RL22: Timer mode leaves output pin unused
// RL23: Zero compare A overflows without A flag
`timescale 1ns/1ps
`include "ptmr_cfg.svh"

module ptmr_core
  import ptmr_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hs_tick,
  input  wire logic        sub_tick,
  input  wire logic        external_clock_pin,
  input  wire logic        capture_input_pin,
  output logic             timer_output_pin,
  output logic             compare_a_flag,
  output logic             compare_p_flag
);

  ptmr_state_t   s_r;
  ptmr_state_t   s_nxt;
  ptmr_apb_req_t req;

  logic             wr_en;
  logic             rd_en;
  logic             on_now;
  logic             on_new;
  logic             on_rise;
  logic [1:0]       mode;
  logic [1:0]       pinf;
  logic             oc;
  logic             tick;
  logic             x_rise;
  logic             x_fall;
  logic             c_rise;
  logic             c_fall;
  logic             trg_rise;
  logic             trg_fall;
  logic             cap_hit;
  logic [CNT_W:0]   nxt_cnt;
  logic [CNT_W:0]   per_ext;
  logic             a_hit;
  logic             p_hit;
  logic             clr_cnt;
  logic             pwm_act;
  logic             single;
  logic [31:0]      rdata;
  logic             hit_map;

  assign req = '{psel, penable, pwrite, paddr, pwdata};

  //////////////////////////////////////////////////////////////////////
  // Register decode
  always_comb begin
    wr_en   = req.psel && req.penable && req.pwrite && s_r.pready;
    rd_en   = req.psel && !req.penable && !s_r.pready;
    hit_map = 1'b1;
    rdata   = '0;
    case (req.paddr)
      `PTMR_OFS_CTL0:  rdata[7:0] = s_r.ctl0;
      `PTMR_OFS_CTL1:  rdata[7:0] = s_r.ctl1;
      // RL21: count read split
      `PTMR_OFS_CNTL:  rdata[7:0] = s_r.cnt[7:0];
      `PTMR_OFS_CNTH:  rdata[1:0] = s_r.cnt[9:8];
      `PTMR_OFS_CMPAL: rdata[7:0] = s_r.cmp_a[7:0];
      `PTMR_OFS_CMPAH: rdata[1:0] = s_r.cmp_a[9:8];
      `PTMR_OFS_PERL:  rdata[7:0] = s_r.period[7:0];
      `PTMR_OFS_PERH:  rdata[1:0] = s_r.period[9:8];
      default:         hit_map    = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Control fields and the on-bit edge
  always_comb begin
    // RL7: mode field decode
    mode   = s_r.ctl1[`PTMR_MODE_HI:`PTMR_MODE_LO];
    pinf   = s_r.ctl1[`PTMR_IO_HI:`PTMR_IO_LO];
    oc     = s_r.ctl1[`PTMR_OC_BIT];
    on_now = s_r.ctl0[`PTMR_ON_BIT];
    on_new = on_now;
    if (wr_en && req.paddr == `PTMR_OFS_CTL0) begin
      on_new = req.pwdata[`PTMR_ON_BIT];
    end
    // RL4: detect off-to-on write
    on_rise = on_new && !on_now;
    single  = (mode == `PTMR_MODE_PWM) && (pinf == `PTMR_IO_11);
  end

  //////////////////////////////////////////////////////////////////////
  // Pin edges, taken between the second and third sync stages
  always_comb begin
    x_rise = s_r.xsync[1] && !s_r.xsync[2];
    x_fall = !s_r.xsync[1] && s_r.xsync[2];
    c_rise = s_r.csync[1] && !s_r.csync[2];
    c_fall = !s_r.csync[1] && s_r.csync[2];
  end

  //////////////////////////////////////////////////////////////////////
  // Count clock selection
  always_comb begin
    // RL3: clock source select
    case (s_r.ctl0[`PTMR_CKS_HI:`PTMR_CKS_LO])
      `PTMR_CK_SYS4:  tick = (s_r.div4 == `PTMR_DIV4_LAST);
      `PTMR_CK_SYS:   tick = 1'b1;
      `PTMR_CK_H16:   tick = hs_tick &&
                             ((s_r.hdiv & `PTMR_H16_MASK) ==
                              `PTMR_H16_MASK);
      `PTMR_CK_H64:   tick = hs_tick &&
                             (s_r.hdiv == `PTMR_H64_LAST);
      `PTMR_CK_SUB0,
      `PTMR_CK_SUB1:  tick = sub_tick;
      `PTMR_CK_XRISE: tick = x_rise;
      `PTMR_CK_XFALL: tick = x_fall;
      default:        tick = 1'b0;
    endcase
    // RL2: pause freezes counting
    tick = tick && on_now && !s_r.ctl0[`PTMR_PAUSE_BIT];
  end

  //////////////////////////////////////////////////////////////////////
  // Comparators
  always_comb begin
    nxt_cnt = {1'b0, s_r.cnt} + {{CNT_W{1'b0}}, 1'b1};
    // RL19: full-width period compare
    per_ext = (s_r.period == '0) ? `PTMR_FULL_PERIOD
                                 : {1'b0, s_r.period};
    p_hit   = tick && (nxt_cnt == per_ext);
    // RL23: zero compare A never matches
    a_hit   = tick && (s_r.cmp_a != '0) &&
              (nxt_cnt == {1'b0, s_r.cmp_a}) &&
              (mode != `PTMR_MODE_CAP);
    clr_cnt = 1'b0;
    case (mode)
      // RL17: clear by A or by P
      `PTMR_MODE_CMP,
      `PTMR_MODE_TMR: clr_cnt = s_r.ctl1[`PTMR_CCLR_BIT] ? a_hit : p_hit;
      // RL18: clear-select ignored here
      `PTMR_MODE_CAP: clr_cnt = p_hit;
      `PTMR_MODE_PWM: clr_cnt = single ? a_hit : p_hit;
      default:        clr_cnt = 1'b0;
    endcase
    // Duty at or beyond the period gives full on-time
    pwm_act = ({1'b0, s_r.cmp_a} >= per_ext) ||
              (s_r.cnt < s_r.cmp_a);
  end

  //////////////////////////////////////////////////////////////////////
  // Capture trigger
  always_comb begin
    // RL14: capture source select
    trg_rise = s_r.ctl1[`PTMR_CAPS_BIT] ? x_rise : c_rise;
    trg_fall = s_r.ctl1[`PTMR_CAPS_BIT] ? x_fall : c_fall;
    // RL13: capture edge choice
    case (pinf)
      `PTMR_IO_00: cap_hit = trg_rise;
      `PTMR_IO_01: cap_hit = trg_fall;
      `PTMR_IO_10: cap_hit = trg_rise || trg_fall;
      default:     cap_hit = 1'b0;
    endcase
    cap_hit = cap_hit && on_now && (mode == `PTMR_MODE_CAP);
  end

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;

    s_nxt.xsync = {s_r.xsync[1:0], external_clock_pin};
    s_nxt.csync = {s_r.csync[1:0], capture_input_pin};
    s_nxt.div4  = s_r.div4 + 2'h1;
    if (hs_tick) begin
      s_nxt.hdiv = s_r.hdiv + 6'h01;
    end

    // APB: answer prepared in setup, completed in access
    s_nxt.pready = rd_en;
    if (rd_en) begin
      s_nxt.prdata  = rdata;
      s_nxt.pslverr = !hit_map;
    end
    if (wr_en) begin
      case (req.paddr)
        `PTMR_OFS_CTL0:
          s_nxt.ctl0 = req.pwdata[7:0] & `PTMR_CTL0_MASK;
        `PTMR_OFS_CTL1:  s_nxt.ctl1 = req.pwdata[7:0];
        `PTMR_OFS_CMPAL: s_nxt.cmp_a[7:0] = req.pwdata[7:0];
        `PTMR_OFS_CMPAH: s_nxt.cmp_a[9:8] = req.pwdata[1:0];
        `PTMR_OFS_PERL:  s_nxt.period[7:0] = req.pwdata[7:0];
        `PTMR_OFS_PERH:  s_nxt.period[9:8] = req.pwdata[1:0];
        // RL6: count has no write path
        default:         s_nxt.ctl0 = s_r.ctl0;
      endcase
    end

    // RL1: advance on selected tick
    if (tick) begin
      s_nxt.cnt = clr_cnt ? '0 : nxt_cnt[CNT_W-1:0];
    end

    // RL13: latch count into compare A
    if (cap_hit) begin
      s_nxt.cmp_a = s_r.cnt;
    end

    // RL20: clear events raise requests
    s_nxt.flag_a = a_hit || cap_hit;
    s_nxt.flag_p = p_hit &&
                   !(s_r.ctl1[`PTMR_CCLR_BIT] &&
                     (mode == `PTMR_MODE_CMP ||
                      mode == `PTMR_MODE_TMR)) &&
                   !single;

    // Output level per mode
    case (mode)
      `PTMR_MODE_CMP: begin
        // RL9: match drives pin
        // RL10: equal level is invisible
        if (a_hit) begin
          case (pinf)
            `PTMR_IO_01: s_nxt.out_lvl = 1'b0;
            `PTMR_IO_10: s_nxt.out_lvl = 1'b1;
            `PTMR_IO_11: s_nxt.out_lvl = !s_r.out_lvl;
            default:     s_nxt.out_lvl = s_r.out_lvl;
          endcase
        end
      end
      `PTMR_MODE_PWM: begin
        // RL11: force or waveform
        // RL15: active level from oc
        case (pinf)
          `PTMR_IO_00: s_nxt.out_lvl = !oc;
          `PTMR_IO_01: s_nxt.out_lvl = oc;
          `PTMR_IO_10: s_nxt.out_lvl = (on_now && pwm_act) ? oc : !oc;
          default:     s_nxt.out_lvl = on_now ? oc : !oc;
        endcase
        // Pulse ends on A match by switching the timer off
        if (single && a_hit) begin
          s_nxt.ctl0[`PTMR_ON_BIT] = 1'b0;
          s_nxt.out_lvl            = !oc;
        end
      end
      default: s_nxt.out_lvl = s_r.out_lvl;
    endcase

    // RL4: off-to-on clears the count
    if (on_rise) begin
      s_nxt.cnt = '0;
      // RL5: restore initial level
      if (mode != `PTMR_MODE_CAP && mode != `PTMR_MODE_TMR) begin
        s_nxt.out_lvl = oc;
      end
    end

    // RL16: polarity inversion
    // RL22: timer mode pin held low
    if (mode == `PTMR_MODE_TMR || mode == `PTMR_MODE_CAP) begin
      s_nxt.pin = 1'b0;
    end else begin
      s_nxt.pin = s_nxt.out_lvl ^ s_r.ctl1[`PTMR_POL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r         <= '0;
      s_r.ctl0    <= `PTMR_RST_CTL0;
      s_r.ctl1    <= `PTMR_RST_CTL1;
      s_r.cmp_a   <= `PTMR_RST_CMP;
      s_r.period  <= `PTMR_RST_CMP;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata           = s_r.prdata;
  assign pready           = s_r.pready;
  assign pslverr          = s_r.pslverr;
  assign timer_output_pin = s_r.pin;
  assign compare_a_flag   = s_r.flag_a;
  assign compare_p_flag   = s_r.flag_p;

endmodule

// ### dv/ptmr_checker.sv
/*
 Checker of the 10-bit timer: APB answer timing, read zeros, pin levels.
 Sees only the core's ports; shadows the control registers from writes.
*/
`timescale 1ns/1ps
module ptmr_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_output_pin,
  input wire logic        compare_a_flag,
  input wire logic        compare_p_flag
);
  logic [7:0] c0_r, c1_r;
  logic [1:0] age_r;
  logic       lvl_r, wr_en, run;
  assign wr_en = psel && penable && pready && pwrite;
  assign run = c0_r[3] && !c0_r[7];
  // Age counts edges since a control write, so pin checks see settled logic
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      age_r <= 2'h0;
      lvl_r <= 1'b0;
    end else begin
      if (wr_en && paddr == 8'h00)
        c0_r <= pwdata[7:0];
      if (wr_en && paddr == 8'h04)
        c1_r <= pwdata[7:0];
      if (wr_en && paddr == 8'h00 && pwdata[3] && !c0_r[3])
        lvl_r <= c1_r[3];
      if (wr_en && paddr < 8'h08)
        age_r <= 2'h0;
      else if (age_r != 2'h3)
        age_r <= age_r + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_rd; pready && !pwrite; endsequence
  sequence s_idle; !run [*3]; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_once; pready |-> psel && penable ##1 !pready; endproperty
  property p_hi_zero;
    s_rd and (paddr == 8'h0C) |-> prdata[31:2] == 30'h0;
  endproperty
  property p_lo_zero;
    s_rd and (paddr == 8'h00) |-> prdata[31:8] == 24'h0 && !prdata[2:0];
  endproperty
  property p_unmapped;
    s_rd and (paddr > 8'h1C) |-> pslverr && prdata == 32'h0;
  endproperty
  property p_idle; s_idle |-> !compare_a_flag && !compare_p_flag; endproperty
  property p_quiet_pin;
    c1_r[6] && c0_r[3] && age_r == 2'h3 |-> !timer_output_pin;
  endproperty
  property p_forced;
    c1_r[7:5] == 3'h4 && c0_r[3] && age_r == 2'h3
      |-> timer_output_pin == (c1_r[3] ~^ c1_r[4] ^ c1_r[2]);
  endproperty
  property p_hold;
    c1_r[7:4] == 4'h0 && c0_r[3] && age_r == 2'h3
      |-> timer_output_pin == (lvl_r ^ c1_r[2]);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_once: assert property (p_once) else $error("ready not one access");
  a_hi_zero: assert property (p_hi_zero)
    else $error("count high upper bits set");
  a_lo_zero: assert property (p_lo_zero)
    else $error("clock control unused bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_idle: assert property (p_idle)
    else $error("flag while stopped");
  a_quiet_pin: assert property (p_quiet_pin)
    else $error("pin driven in timer or capture mode");
  a_forced: assert property (p_forced)
    else $error("forced level wrong");
  a_hold: assert property (p_hold)
    else $error("pin left initial level");
endmodule

bind ptmr_core ptmr_checker u_chk (.clk_sys, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .timer_output_pin, .compare_a_flag, .compare_p_flag);

// ### dv/test_ptmr_core.sv
/*
 Self-checking bench of the 10-bit timer, driven over APB.
 Assumes package, core and checker are compiled before it.
*/
`timescale 1ns/1ps
module test_ptmr_core;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        hs_tick, sub_tick, external_clock_pin, capture_input_pin;
  logic        timer_output_pin, compare_a_flag, compare_p_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, tests_run, n, na, nt, v;
  int          cyc = 0;
  int          div[8] = '{4, 1, 32, 128, 8, 8, 10, 10};
  int          pio[4] = '{2, 2, 0, 1};
  int          pa[4] = '{3, 9, 3, 3};
  int          pe[4] = '{24, 64, 0, 64};
  int          ce[4] = '{1, 1, 2, 0};

  ptmr_core DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hs_tick, .sub_tick,
    .external_clock_pin, .capture_input_pin, .timer_output_pin,
    .compare_a_flag, .compare_p_flag);

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Tick sources: fast enable every 2, slow every 8, pin period 10
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    hs_tick <= (cyc % 2 == 0);
    sub_tick <= (cyc % 8 == 0);
    external_clock_pin <= (cyc % 10 < 5);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // One idle edge after each transfer keeps drivers single per step
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rdc(string s, logic [7:0] a, logic [31:0] e);
    apb(0, a, 0);
    chk(s, e, rd);
  endtask
  task automatic wait_f(logic s);
    do
      @(posedge clk_sys);
    while ((s ? compare_a_flag : compare_p_flag) !== 1'b1);
  endtask
  task automatic gap(output int g);
    wait_f(0);
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (compare_p_flag !== 1'b1);
  endtask
  task automatic cnt(int w);
    na = 0;
    nt = 0;
    repeat (w) begin
      @(posedge clk_sys);
      na += int'(compare_a_flag === 1'b1);
      nt += int'(timer_output_pin === 1'b1);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, n_mismatch, tests_run} = {1'b1, 64'h0};
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    capture_input_pin = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    for (int a = 0; a < 8; a++)
      rdc("reset", 8'(a * 4), 0);
    rdc("unmapped", 8'h20, 0);
    chk("slverr", 1, err);
    wr(8'h04, 8'hFF);
    rdc("ctl1", 8'h04, 8'hFF);
    wr(8'h04, 8'hC0);
    wr(8'h00, 8'h77);
    rdc("ctl0", 8'h00, 8'h70);
    wr(8'h14, 8'hFF);
    rdc("cmpa_hi", 8'h14, 8'h03);
    wr(8'h08, 8'h55);
    rdc("cnt_ro", 8'h08, 0);
    wr(8'h18, 3);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 8'(i << 4));
      wr(8'h00, 8'(i << 4 | 8));
      gap(n);
      chk("clk_gap", 3 * div[i], n);
    end
    wr(8'h00, 8'h10);
    wr(8'h04, 0);
    wr(8'h18, 0);
    wr(8'h14, 0);
    wr(8'h10, 0);
    wr(8'h00, 8'h18);
    gap(n);
    chk("overflow", 1024, n);
    cnt(1300);
    chk("no_a_flag", 0, na);
    wr(8'h00, 8'h10);
    apb(0, 8'h08, 0);
    v = rd;
    rdc("cnt_hi", 8'h0C, 1);
    repeat (20) @(posedge clk_sys);
    rdc("off_hold", 8'h08, v);
    wr(8'h00, 8'h98);
    rdc("on_clear", 8'h08, 0);
    wr(8'h00, 8'h18);
    repeat (50) @(posedge clk_sys);
    wr(8'h00, 8'h98);
    apb(0, 8'h08, 0);
    v = rd;
    chk("running", 1, v > 40);
    repeat (20) @(posedge clk_sys);
    rdc("paused", 8'h08, v);
    wr(8'h10, 20);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 8'h10);
      wr(8'h04, {2'b00, 2'(i), 1'(i / 4), 1'(i), 2'b01});
      wr(8'h00, 8'h18);
      repeat (2) @(posedge clk_sys);
      chk("init_lvl", (i / 4) ^ (i % 2), timer_output_pin);
      wait_f(1);
      repeat (3) @(posedge clk_sys);
      v = (i % 4 == 0) ? i / 4 : (i % 4 == 3) ? 1 - i / 4 : i / 2 % 2;
      chk("match_lvl", v ^ (i % 2), timer_output_pin);
    end
    wr(8'h18, 8);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'h10);
      wr(8'h04, {2'b10, 2'(pio[i]), 4'b1000});
      wr(8'h10, pa[i]);
      wr(8'h00, 8'h18);
      repeat (4) @(posedge clk_sys);
      cnt(64);
      chk("pwm_high", pe[i], nt);
    end
    wr(8'h00, 8'h10);
    wr(8'h04, 8'hB8);
    wr(8'h10, 30);
    wr(8'h00, 8'h18);
    repeat (2) @(posedge clk_sys);
    chk("pulse_on", 1, timer_output_pin);
    wait_f(1);
    repeat (3) @(posedge clk_sys);
    chk("pulse_pin", 0, timer_output_pin);
    rdc("pulse_off", 8'h00, 8'h10);
    wr(8'h18, 0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'h10);
      wr(8'h04, {2'b01, 2'(i), 4'b0000});
      wr(8'h00, 8'h18);
      capture_input_pin <= 1;
      cnt(10);
      v = na;
      capture_input_pin <= 0;
      cnt(10);
      chk("capture", ce[i], v + na);
    end
    wr(8'h00, 8'h10);
    wr(8'h04, 8'h42);
    wr(8'h00, 8'h18);
    repeat (20) @(posedge clk_sys);
    cnt(100);
    chk("capture_clk_pin", 10, na);
    wrap_up();
  end
endmodule
